// ===== src/drcs_top.sv
`timescale 1ns/1ps
`include "drcs_params.svh"

// Functional notes
// - Any RAM byte can be reached indirectly through pointer locations 0 and 1 (bank 0) or 24 and 25 (bank 1).
// - With bank 0 selected the working registers are RAM locations 0-7.
// - With bank 1 selected the working registers move to RAM locations 24-31.
// - Locations 8-23 hold the stack, two bytes per call, eight levels deep.
// - Up to 256 bytes of external data RAM are reached by the external move access.
// - The program counter is a 12-bit register holding the next fetch address.
// - Fetches go external once the counter passes the internal program memory size.
// - While the synchronised external access pin is high every fetch goes external.
// - A call or interrupt saves the counter in the pair chosen by the 3-bit stack pointer.
// - Each stack entry holds the full counter plus four status bits.
// - Pointer value 000 selects locations 8 and 9, each step moving two locations.
// - After the entry is stored the stack pointer is incremented.
// - An eighth push wraps the pointer from 111 to 000; a ninth overwrites 8 and 9 silently.
// - Decrementing the pointer from 000 wraps it to 111.
// - A return first decrements the pointer, then reloads the counter from that pair.

module drcs_top
  import drcs_pkg::*;
#(
  parameter int RAM_DEPTH = `DRCS_RAM_DEPTH,
  parameter int INT_ROM_BYTES = `DRCS_INT_ROM_BYTES
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Data access port
  input wire drcs_acc_s acc_i,
  input wire logic bank_sel_i,
  output logic acc_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Stack control from the sequencer
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [3:0] psw_hi_i,
  input wire logic sp_load_i,
  input wire logic [2:0] sp_wdata_i,
  output logic stk_ready_o,
  output logic pop_done_o,
  output logic [3:0] psw_hi_o,
  output logic [2:0] sp_o,
  // Program counter
  input wire logic pc_load_i,
  input wire logic [11:0] pc_load_val_i,
  input wire logic pc_inc_i,
  output logic [11:0] pc_o,
  // Fetch source
  input wire logic external_access_pin_i,
  output logic fetch_ext_o,
  // External data RAM
  output logic [7:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  output logic ext_rd_o,
  output logic ext_wr_o,
  input wire logic [7:0] ext_rdata_i
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------

  // Working register location for a bank and register index
  function automatic logic [7:0] wreg_addr(input logic bank, input logic [2:0] idx);
    wreg_addr = (bank ? `DRCS_BANK1_BASE : `DRCS_BANK0_BASE) + {5'h00, idx};
  endfunction

  // Stack byte location for a pointer value and byte half
  function automatic logic [7:0] stk_addr(input logic [2:0] sp, input logic hi);
    stk_addr = `DRCS_STACK_BASE + {4'h0, sp, hi};
  endfunction

  // ----------------------------------------------------------------
  // State and wiring
  // ----------------------------------------------------------------
  drcs_state_e state_q;
  drcs_state_e state_d;
  logic [2:0] sp_q;
  logic [11:0] pc_q;
  logic [3:0] psw_hi_q;
  logic [7:0] hold_q;
  logic [7:0] ptr_q [4];
  logic int_rd_q;
  logic ext_busy_q;
  logic ext_vld_q;
  logic [7:0] ext_rdq;
  logic idle;
  logic push_go;
  logic pop_go;
  logic acc_go;
  logic [7:0] acc_addr;
  logic [7:0] ram_addr;
  logic ram_we;
  logic ram_re;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;

  assign idle = (state_q == DRCS_ST_IDLE);
  assign push_go = idle && push_i;
  assign pop_go = idle && pop_i && !push_i;

  // Stack work wins the RAM port; a cycle after an external read is
  // refused so both read paths never answer in the same cycle
  assign acc_ready_o = idle && !push_i && !pop_i && !ext_busy_q;
  assign acc_go = acc_ready_o && (acc_i.rd || acc_i.wr);
  assign stk_ready_o = idle;

  // ----------------------------------------------------------------
  // Access address resolution
  // ----------------------------------------------------------------

  // Pointers are working registers 0 and 1 of the current bank
  always_comb
  begin
    unique case (acc_i.mode)
      DRCS_ACC_DIRECT: acc_addr = acc_i.addr;
      DRCS_ACC_WREG: acc_addr = wreg_addr(bank_sel_i, acc_i.addr[2:0]);
      DRCS_ACC_IND0: acc_addr = ptr_q[{bank_sel_i, 1'b0}];
      DRCS_ACC_IND1: acc_addr = ptr_q[{bank_sel_i, 1'b1}];
    endcase
  end

  // ----------------------------------------------------------------
  // RAM port steering
  // ----------------------------------------------------------------

  // Stack states own the port; otherwise the internal access does
  always_comb
  begin
    ram_addr = acc_addr;
    ram_we = acc_go && acc_i.wr && !acc_i.ext;
    ram_re = acc_go && acc_i.rd && !acc_i.ext;
    ram_wdata = acc_i.wdata;
    unique case (state_q)
      DRCS_ST_IDLE:
      begin
        if (push_go)
        begin
          ram_addr = stk_addr(sp_q, 1'b0);
          ram_we = 1'b1;
          ram_re = 1'b0;
          ram_wdata = pc_q[7:0];
        end
      end
      DRCS_ST_PUSH_HI:
      begin
        ram_addr = stk_addr(sp_q, 1'b1);
        ram_we = 1'b1;
        ram_re = 1'b0;
        ram_wdata = {psw_hi_q, hold_q[3:0]};
      end
      DRCS_ST_POP_RDLO:
      begin
        ram_addr = stk_addr(sp_q, 1'b0);
        ram_we = 1'b0;
        ram_re = 1'b1;
      end
      DRCS_ST_POP_RDHI:
      begin
        ram_addr = stk_addr(sp_q, 1'b1);
        ram_we = 1'b0;
        ram_re = 1'b1;
      end
      DRCS_ST_POP_DONE:
      begin
        ram_we = 1'b0;
        ram_re = 1'b0;
      end
    endcase
  end

  drcs_ram #(
    .DEPTH(RAM_DEPTH),
    .WIDTH(8)
  ) u_ram (
    .clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .addr_i(ram_addr),
    .we_i(ram_we),
    .re_i(ram_re),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // ----------------------------------------------------------------
  // Pointer shadows
  // ----------------------------------------------------------------

  // Copies of both banks' pointer bytes, so an indirect access needs no
  // extra RAM read; they track every write to those four locations
  for (genvar g = 0; g < 4; g++)
  begin : g_ptr
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        ptr_q[g] <= 8'h00;
      end
      else if (ram_we && ram_addr == wreg_addr(1'(g / 2), 3'(g % 2)))
      begin
        ptr_q[g] <= ram_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack sequencer
  // ----------------------------------------------------------------

  // Push takes two cycles, pop four
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DRCS_ST_IDLE:
      begin
        if (push_go)
        begin
          state_d = DRCS_ST_PUSH_HI;
        end
        else if (pop_go)
        begin
          state_d = DRCS_ST_POP_RDLO;
        end
      end
      DRCS_ST_PUSH_HI: state_d = DRCS_ST_IDLE;
      DRCS_ST_POP_RDLO: state_d = DRCS_ST_POP_RDHI;
      DRCS_ST_POP_RDHI: state_d = DRCS_ST_POP_DONE;
      DRCS_ST_POP_DONE: state_d = DRCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= DRCS_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Hold register: counter high bits on push, low byte on pop
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hold_q <= 8'h00;
    end
    else if (push_go)
    begin
      hold_q <= {4'h0, pc_q[11:8]};
    end
    else if (state_q == DRCS_ST_POP_DONE && $bits(hold_q) == 8)
    begin
      hold_q <= hold_q;
    end
    else if (state_q == DRCS_ST_POP_RDHI)
    begin
      hold_q <= ram_rdata; // Low byte arrives here
    end
  end

  // Status bits saved with the entry, captured at the push request
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      psw_hi_q <= `DRCS_PSW_RST;
    end
    else if (push_go)
    begin
      psw_hi_q <= psw_hi_i;
    end
    else if (state_q == DRCS_ST_POP_DONE)
    begin
      psw_hi_q <= ram_rdata[7:4]; // Restored status bits
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------

  // Increment only after the second byte lands; wraps silently both ways
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sp_q <= `DRCS_SP_RST;
    end
    else if (state_q == DRCS_ST_PUSH_HI)
    begin
      sp_q <= sp_q + 3'h1;
    end
    else if (pop_go)
    begin
      sp_q <= sp_q - 3'h1;
    end
    else if (idle && !push_i && sp_load_i)
    begin
      sp_q <= sp_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------

  // Return reload beats a load, a load beats an increment
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_q <= `DRCS_PC_RST;
    end
    else if (state_q == DRCS_ST_POP_DONE)
    begin
      pc_q <= {ram_rdata[3:0], hold_q};
    end
    else if (pc_load_i)
    begin
      pc_q <= pc_load_val_i;
    end
    else if (pc_inc_i)
    begin
      pc_q <= pc_q + 12'h001;
    end
  end

  drcs_fetch #(
    .INT_ROM_BYTES(INT_ROM_BYTES)
  ) u_fetch (
    .clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .pc_i(pc_q),
    .external_access_pin_i(external_access_pin_i),
    .fetch_ext_o(fetch_ext_o)
  );

  // ----------------------------------------------------------------
  // External data RAM
  // ----------------------------------------------------------------

  // Registered strobes; the upper bank bits come from an I/O port elsewhere
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_addr_o <= 8'h00;
      ext_wdata_o <= 8'h00;
      ext_rd_o <= 1'b0;
      ext_wr_o <= 1'b0;
    end
    else
    begin
      ext_rd_o <= acc_go && acc_i.ext && acc_i.rd;
      ext_wr_o <= acc_go && acc_i.ext && acc_i.wr;
      if (acc_go && acc_i.ext)
      begin
        ext_addr_o <= acc_addr;
        ext_wdata_o <= acc_i.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------

  // Internal reads answer next cycle, external ones the cycle after
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      int_rd_q <= 1'b0;
      ext_busy_q <= 1'b0;
      ext_vld_q <= 1'b0;
      ext_rdq <= 8'h00;
    end
    else
    begin
      int_rd_q <= acc_go && acc_i.rd && !acc_i.ext;
      ext_busy_q <= acc_go && acc_i.rd && acc_i.ext;
      ext_vld_q <= ext_rd_o;
      if (ext_rd_o)
      begin
        ext_rdq <= ext_rdata_i;
      end
    end
  end

  assign rd_valid_o = int_rd_q || ext_vld_q;
  assign rd_data_o = ext_vld_q ? ext_rdq : ram_rdata;
  assign pop_done_o = (state_q == DRCS_ST_POP_DONE);
  assign psw_hi_o = psw_hi_q;
  assign sp_o = sp_q;
  assign pc_o = pc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_push_even_slot: assert property (push_go |-> ram_we && ram_addr == stk_addr(sp_q, 1'b0)
    && ram_wdata == pc_q[7:0]) else $error("push low byte misplaced");
  a_push_odd_byte: assert property (push_go |=> ram_we && ram_addr == $past(ram_addr) + 8'h01
    && ram_wdata == {$past(psw_hi_i), $past(pc_q[11:8])}) else $error("push high byte wrong");
  a_push_sp_step: assert property (push_go |-> ##2 sp_q == $past(sp_q, 2) + 3'h1)
    else $error("stack pointer not advanced after push");
  a_push_wrap: assert property (push_go && sp_q == 3'h7 |-> ##2 sp_q == 3'h0)
    else $error("stack pointer failed to wrap to 000");
  a_pop_wrap: assert property (pop_go && sp_q == 3'h0 |=> sp_q == 3'h7)
    else $error("stack pointer failed to wrap to 111");
  a_pop_reads_new: assert property (pop_go |=> ram_re && ram_addr == stk_addr($past(sp_q) - 3'h1, 1'b0))
    else $error("return read the wrong pair");
  a_pop_pc_reload: assert property (pop_go |-> ##3 pop_done_o ##1
    pc_q == {$past(ram_rdata[3:0]), $past(hold_q)}) else $error("counter not restored on return");
  a_stack_window: assert property (!idle |-> (ram_addr >= `DRCS_STACK_BASE && ram_addr <= `DRCS_STACK_LAST)
    || state_q == DRCS_ST_POP_DONE) else $error("stack access outside 8-23");
  a_wreg_bank0: assert property (acc_go && acc_i.mode == DRCS_ACC_WREG && !bank_sel_i |-> ram_addr <= 8'h07)
    else $error("bank 0 register outside 0-7");
  a_wreg_bank1: assert property (acc_go && acc_i.mode == DRCS_ACC_WREG && bank_sel_i
    |-> ram_addr >= 8'h18 && ram_addr <= 8'h1F) else $error("bank 1 register outside 24-31");
  a_ind_follows: assert property (ram_we && ram_addr == `DRCS_PTR0_LOC ##1 !ram_we ##1 acc_go && !bank_sel_i
    && acc_i.mode == DRCS_ACC_IND0 |-> ram_addr == $past(ram_wdata, 2)) else $error("indirect address stale");
  a_ext_strobe: assert property (acc_go && acc_i.ext && acc_i.rd |=> ext_rd_o ##1 rd_valid_o)
    else $error("external read not issued");

  c_push: cover property (push_go ##2 idle);
  c_pop: cover property (pop_go ##3 pop_done_o);
  c_wrap: cover property (push_go && sp_q == 3'h7);
  c_indirect: cover property (acc_go && acc_i.mode == DRCS_ACC_IND1 && acc_i.rd);

endmodule // drcs_top

// ===== src/drcs_params.svh
`ifndef DRCS_PARAMS_SVH
`define DRCS_PARAMS_SVH

// ----------------------------------------------------------------
// Resident RAM map
// ----------------------------------------------------------------
`define DRCS_PTR0_LOC 8'h00
`define DRCS_PTR1_LOC 8'h01
`define DRCS_BANK0_BASE 8'h00
`define DRCS_BANK1_BASE 8'h18
`define DRCS_STACK_BASE 8'h08
`define DRCS_STACK_LAST 8'h17
`define DRCS_RAM_DEPTH 256
`define DRCS_EXT_DEPTH 256

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define DRCS_SP_RST 3'h0
`define DRCS_PC_RST 12'h000
`define DRCS_PSW_RST 4'h0
`define DRCS_INT_ROM_BYTES 2048
`define DRCS_PC_SPAN 4096

`endif

// ===== src/drcs_pkg.sv
package drcs_pkg;

  // Data access kinds on the access port
  typedef enum logic [1:0] {
    DRCS_ACC_DIRECT = 2'h0,
    DRCS_ACC_WREG = 2'h1,
    DRCS_ACC_IND0 = 2'h2,
    DRCS_ACC_IND1 = 2'h3
  } drcs_acc_e;

  // One request on the access port
  typedef struct packed {
    drcs_acc_e mode;
    logic ext;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } drcs_acc_s;

  // Stack sequencer states
  typedef enum logic [4:0] {
    DRCS_ST_IDLE = 5'h01,
    DRCS_ST_PUSH_HI = 5'h02,
    DRCS_ST_POP_RDLO = 5'h04,
    DRCS_ST_POP_RDHI = 5'h08,
    DRCS_ST_POP_DONE = 5'h10
  } drcs_state_e;

endpackage

// ===== src/drcs_ram.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Resident data RAM, single port, registered read data
// ----------------------------------------------------------------
module drcs_ram
  import drcs_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Access
  input wire logic [7:0] addr_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  localparam int AW = $clog2(DEPTH);

  // Stack and bank 1 need locations up to 31; the address is 8 bits wide
  if (DEPTH < 64 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("drcs_ram: DEPTH must be a power of two from 64 to 256");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Array holds no reset; addresses at or above DEPTH fold onto low locations
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i[AW-1:0]] <= wdata_i;
    end
  end

  // Read data register, updated only by a read
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= '0;
    end
    else if (re_i)
    begin
      rdata_o <= mem[addr_i[AW-1:0]];
    end
  end

endmodule // drcs_ram

// ===== src/drcs_fetch.sv
`timescale 1ns/1ps
`include "drcs_params.svh"

// ----------------------------------------------------------------
// Program fetch source select
// ----------------------------------------------------------------
module drcs_fetch
  import drcs_pkg::*;
#(
  parameter int INT_ROM_BYTES = `DRCS_INT_ROM_BYTES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Counter and pin
  input wire logic [11:0] pc_i,
  input wire logic external_access_pin_i,
  // Result
  output logic fetch_ext_o
);

  if (INT_ROM_BYTES < 0 || INT_ROM_BYTES > `DRCS_PC_SPAN)
  begin : g_bad_rom
    $error("drcs_fetch: INT_ROM_BYTES must lie in 0..4096");
  end

  localparam logic [12:0] ROM_END = 13'(INT_ROM_BYTES);

  logic ea_meta_q;
  logic ea_sync_q;

  // Pin synchroniser, first stage read by the second only
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ea_meta_q <= 1'b0;
      ea_sync_q <= 1'b0;
    end
    else
    begin
      ea_meta_q <= external_access_pin_i;
      ea_sync_q <= ea_meta_q;
    end
  end

  // Pin forces external; otherwise external past the internal boundary
  assign fetch_ext_o = ea_sync_q || ({1'b0, pc_i} >= ROM_END);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_pin_forces_ext: assert property ($past(external_access_pin_i, 2) && $past(external_access_pin_i, 1)
    && $past(arst_n_i, 2) |-> fetch_ext_o) else $error("pin high but fetch stayed internal");
  a_rom_boundary: assert property (!ea_sync_q |-> (fetch_ext_o == ({1'b0, pc_i} >= ROM_END)))
    else $error("fetch source wrong at internal boundary");

endmodule // drcs_fetch

// ===== verif/drcs_ext_ram_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External data RAM, two 256-byte pages picked by a port bit
// ----------------------------------------------------------------
module drcs_ext_ram_model
  import drcs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Strobes and address from the block
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  // Page select, driven from an I/O port
  input wire logic page_i,
  // Read data back to the block
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [512];
  logic [7:0] last_q = 8'hA5;

  // Byte write into the selected page
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem_q[{page_i, addr_i}] <= wdata_i;
  end

  // Remember the last driven byte so the idle bus shows its inverse
  always @(posedge clk_i)
  begin
    if (rd_i)
      last_q <= rdata_o;
  end

  // Data only while the read strobe stands, otherwise no stale copy
  assign rdata_o = rd_i ? mem_q[{page_i, addr_i}] : ~last_q;
endmodule // drcs_ext_ram_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps

module tb_top
  import drcs_pkg::*;
;
  logic ref_clk_i, arst_n_i, bank_sel_i, push_i, pop_i, sp_load_i, pc_load_i, pc_inc_i, pin, page;
  logic acc_ready_o, rd_valid_o, stk_ready_o, pop_done_o, fetch_ext_o, ext_rd_o, ext_wr_o;
  logic [3:0] psw_hi_i, psw_hi_o;
  logic [2:0] sp_wdata_i, sp_o;
  logic [11:0] pc_load_val_i, pc_o;
  logic [7:0] rd_data_o, ext_addr_o, ext_wdata_o, ext_rdata_i, rdv;
  drcs_acc_s acc_i;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  logic done;

  drcs_top uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .acc_i(acc_i), .bank_sel_i(bank_sel_i),
    .acc_ready_o(acc_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .push_i(push_i),
    .pop_i(pop_i), .psw_hi_i(psw_hi_i), .sp_load_i(sp_load_i), .sp_wdata_i(sp_wdata_i),
    .stk_ready_o(stk_ready_o), .pop_done_o(pop_done_o), .psw_hi_o(psw_hi_o), .sp_o(sp_o),
    .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i), .pc_inc_i(pc_inc_i), .pc_o(pc_o),
    .external_access_pin_i(pin), .fetch_ext_o(fetch_ext_o), .ext_addr_o(ext_addr_o),
    .ext_wdata_o(ext_wdata_o), .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o), .ext_rdata_i(ext_rdata_i));

  drcs_ext_ram_model ext_ram (.clk_i(ref_clk_i), .addr_i(ext_addr_o), .wdata_i(ext_wdata_o),
    .rd_i(ext_rd_o), .wr_i(ext_wr_o), .page_i(page), .rdata_o(ext_rdata_i));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until an edge sees ready; read data wait bounded
  task automatic acc(input drcs_acc_e m, input logic x, input logic [7:0] a, input logic [7:0] d,
      input logic w);
    int n;
    n = 0;
    acc_i <= '{mode: m, ext: x, addr: a, wdata: d, wr: w, rd: !w};
    do @(posedge ref_clk_i); while (acc_ready_o !== 1'b1 && ++n < 20);
    acc_i.wr <= 1'b0;
    acc_i.rd <= 1'b0;
    n = 0;
    if (w)
      @(posedge ref_clk_i);
    else
    begin
      do @(posedge ref_clk_i); while (rd_valid_o !== 1'b1 && ++n < 8);
      rdv = (rd_valid_o === 1'b1) ? rd_data_o : 8'hXX;
    end
  endtask

  // Push or pop, then wait for the sequencer to go idle again
  task automatic stk(input logic is_pop);
    int n;
    n = 0;
    done = 1'b0;
    if (is_pop)
      pop_i <= 1'b1;
    else
      push_i <= 1'b1;
    do @(posedge ref_clk_i); while (stk_ready_o !== 1'b1 && ++n < 20);
    pop_i <= 1'b0;
    push_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      done = done | (pop_done_o === 1'b1);
    end
    while (stk_ready_o !== 1'b1 && ++n < 20);
  endtask

  task automatic setpc(input logic [11:0] v);
    pc_load_i <= 1'b1;
    pc_load_val_i <= v;
    @(posedge ref_clk_i);
    pc_load_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Expected counter value saved in the stack entry by push number k
  function automatic logic [11:0] epc(input int k);
    return {k[3:0] + 4'h1, 4'h5, k[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    arst_n_i = 1'b0;
    acc_i = '0;
    {bank_sel_i, push_i, pop_i, sp_load_i, pc_load_i, pc_inc_i, pin, page} = '0;
    psw_hi_i = 4'h0;
    sp_wdata_i = 3'h0;
    pc_load_val_i = 12'h000;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(sp_o, 12'h000);
    chk(pc_o, 12'h000);
    chk(psw_hi_o, 12'h000);
    // Working registers in both banks
    acc(DRCS_ACC_WREG, 1'b0, 8'h02, 8'h11, 1'b1);
    acc(DRCS_ACC_DIRECT, 1'b0, 8'h02, 8'h00, 1'b0);
    chk(rdv, 12'h011);
    bank_sel_i <= 1'b1;
    acc(DRCS_ACC_WREG, 1'b0, 8'h03, 8'h22, 1'b1);
    bank_sel_i <= 1'b0;
    acc(DRCS_ACC_DIRECT, 1'b0, 8'h1B, 8'h00, 1'b0);
    chk(rdv, 12'h022);
    // Indirect through pointer 0 in bank 0 and pointer 1 in bank 1
    acc(DRCS_ACC_DIRECT, 1'b0, 8'h00, 8'h40, 1'b1);
    acc(DRCS_ACC_IND0, 1'b0, 8'h00, 8'h5A, 1'b1);
    acc(DRCS_ACC_DIRECT, 1'b0, 8'h40, 8'h00, 1'b0);
    chk(rdv, 12'h05A);
    bank_sel_i <= 1'b1;
    acc(DRCS_ACC_DIRECT, 1'b0, 8'h19, 8'hC8, 1'b1);
    acc(DRCS_ACC_DIRECT, 1'b0, 8'hC8, 8'hC3, 1'b1);
    acc(DRCS_ACC_IND1, 1'b0, 8'h00, 8'h00, 1'b0);
    chk(rdv, 12'h0C3);
    bank_sel_i <= 1'b0;
    // External RAM on two port-selected pages
    acc(DRCS_ACC_DIRECT, 1'b1, 8'hFF, 8'h3C, 1'b1);
    page <= 1'b1;
    acc(DRCS_ACC_DIRECT, 1'b1, 8'hFF, 8'hC5, 1'b1);
    acc(DRCS_ACC_DIRECT, 1'b1, 8'hFF, 8'h00, 1'b0);
    chk(rdv, 12'h0C5);
    page <= 1'b0;
    acc(DRCS_ACC_DIRECT, 1'b1, 8'hFF, 8'h00, 1'b0);
    chk(rdv, 12'h03C);
    // Nine nested pushes, the eighth wraps the pointer and the last one overwrites 8 and 9
    for (int k = 0; k < 9; k++)
    begin
      setpc(epc(k));
      psw_hi_i <= 4'hF - k[3:0];
      stk(1'b0);
      chk(sp_o, 12'((k + 1) % 8));
    end
    for (int k = 0; k < 8; k++)
    begin
      acc(DRCS_ACC_DIRECT, 1'b0, 8'h08 + 8'(2 * k), 8'h00, 1'b0);
      chk(rdv, epc(k == 0 ? 8 : k) & 12'h0FF);
      acc(DRCS_ACC_DIRECT, 1'b0, 8'h09 + 8'(2 * k), 8'h00, 1'b0);
      chk(rdv, {4'h0, 4'hF - 4'(k == 0 ? 8 : k), 4'(epc(k == 0 ? 8 : k) >> 8)});
    end
    // Returns: decrement first, then reload; underflow wraps to 7
    stk(1'b1);
    chk(sp_o, 12'h000);
    chk(pc_o, epc(8));
    chk(psw_hi_o, 12'h007);
    chk(done, 12'h001);
    stk(1'b1);
    chk(sp_o, 12'h007);
    chk(pc_o, epc(7));
    // Status word load of the pointer
    sp_load_i <= 1'b1;
    sp_wdata_i <= 3'h5;
    @(posedge ref_clk_i);
    sp_load_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(sp_o, 12'h005);
    // Counter width and fetch source boundary
    setpc(12'h7FF);
    chk(fetch_ext_o, 12'h000);
    pc_inc_i <= 1'b1;
    @(posedge ref_clk_i);
    pc_inc_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(pc_o, 12'h800);
    chk(fetch_ext_o, 12'h001);
    setpc(12'hFFF);
    pc_inc_i <= 1'b1;
    @(posedge ref_clk_i);
    pc_inc_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(pc_o, 12'h000);
    pin <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk(fetch_ext_o, 12'h001);
    pin <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(fetch_ext_o, 12'h000);
    end_of_test();
  end
endmodule // tb_top
